// file: core/csgo_params.svh
// constants for the store, guard and string object entries
`ifndef CSGO_PARAMS_SVH
`define CSGO_PARAMS_SVH

// object indices
`define CSGO_IDX_SYNC 16'h1005
`define CSGO_IDX_NAME 16'h1008
`define CSGO_IDX_HWVER 16'h1009
`define CSGO_IDX_SWVER 16'h100A
`define CSGO_IDX_GUARD 16'h100C
`define CSGO_IDX_LIFE 16'h100D
`define CSGO_IDX_SAVE 16'h1010
`define CSGO_IDX_RESTORE 16'h1011

// field positions and reset values
`define CSGO_SYNC_GEN_BIT 30
`define CSGO_SYNC_RESET 32'h0000_0080
`define CSGO_GUARD_RESET 16'h0000
`define CSGO_LIFE_RESET 8'h00
`define CSGO_HIGHEST_SUB 32'h0000_0005
`define CSGO_LAST_GROUP_SUB 8'h04
`define CSGO_RESERVED_SUB 8'h05
`define CSGO_COMM_GROUP_SUB 8'h02

// strings, arbitrary values
`define CSGO_NAME_STR 32'h3156_5244
`define CSGO_HWVER_STR 32'h3031_5748
`define CSGO_SWVER_STR 32'h3031_5753

// signatures and capability words
`define CSGO_SIG_SAVE 32'h6576_6173
`define CSGO_SIG_LOAD 32'h6461_6F6C
`define CSGO_SAVE_CAP 32'h0000_0001
`define CSGO_RESTORE_CAP 32'h0000_0001

// abort codes
`define CSGO_AB_STORE_FAIL 32'h0606_0000
`define CSGO_AB_BAD_SIG 32'h0800_0020
`define CSGO_AB_STATE 32'h0800_0022
`define CSGO_AB_READ_ONLY 32'h0601_0002
`define CSGO_AB_NO_SUB 32'h0609_0011
`define CSGO_AB_NO_OBJ 32'h0602_0000

// timing
`define CSGO_CLK_MHZ 200
`define CSGO_MS_US 1000
`define CSGO_MS_CYCLES (`CSGO_CLK_MHZ * `CSGO_MS_US)
`define CSGO_SYNC_PERIOD_US 1000
`define CSGO_SYNC_CYCLES (`CSGO_CLK_MHZ * `CSGO_SYNC_PERIOD_US)

`endif

// file: core/csgo_pkg.sv
// types shared by the store, guard and string object block
package csgo_pkg;

    typedef struct packed {
        logic write;
        logic [15:0] index;
        logic [7:0] sub;
        logic [31:0] data;
    } csgo_req_t;

    typedef struct packed {
        logic abort;
        logic [31:0] data;
    } csgo_rsp_t;

    typedef enum logic [0:0] {
        CSGO_IDLE = 1'b0,
        CSGO_SAVING = 1'b1
    } csgo_state_t;

endpackage

// file: core/csgo_store_guard.sv
// object entries for sync, guarding, strings, save and restore
`timescale 1ns/100ps
`default_nettype none
`include "csgo_params.svh"

module csgo_store_guard
    import csgo_pkg::*;
#(
    parameter int unsigned MS_CYCLES = `CSGO_MS_CYCLES,
    parameter int unsigned SYNC_CYCLES = `CSGO_SYNC_CYCLES
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // object access from the sdo server
    input wire logic reqValid,
    input wire csgo_req_t req,
    output csgo_rsp_t rsp,
    output logic rspValid,
    // non-volatile store handshake
    output logic storeReq,
    output logic [7:0] storeGroup,
    input wire logic storeDone,
    input wire logic storeFail,
    // restore of defaults
    input wire logic nmtResetNode,
    input wire logic nmtResetComm,
    output logic restorePending,
    output logic restoreApply,
    output logic [7:0] restoreGroup,
    // drive state and warning
    input wire logic driveOpEnabled,
    input wire logic driveQuickStop,
    output logic warnPulse,
    output logic warnSaveRefused,
    // heartbeat and guarding
    input wire logic [15:0] heartbeatTime,
    input wire logic guardRequest,
    output logic guardActive,
    output logic lifeExpired,
    // sync production
    output logic syncProducer,
    output logic syncPulse,
    output logic [10:0] syncCobId
);

    // ------------------------------------------------------------
    // entry storage
    // ------------------------------------------------------------
    logic [31:0] syncId;
    logic [15:0] guardTime;
    logic [7:0] lifeFactor;
    csgo_state_t state;
    logic [7:0] pendGroup;

    // ------------------------------------------------------------
    // request decode
    // ------------------------------------------------------------
    wire logic isSync = req.index == `CSGO_IDX_SYNC;
    wire logic isName = req.index == `CSGO_IDX_NAME;
    wire logic isHw = req.index == `CSGO_IDX_HWVER;
    wire logic isSw = req.index == `CSGO_IDX_SWVER;
    wire logic isGuard = req.index == `CSGO_IDX_GUARD;
    wire logic isLife = req.index == `CSGO_IDX_LIFE;
    wire logic isSave = req.index == `CSGO_IDX_SAVE;
    wire logic isRest = req.index == `CSGO_IDX_RESTORE;
    wire logic isVar = isSync | isName | isHw | isSw | isGuard | isLife;
    wire logic isArr = isSave | isRest;
    wire logic subZero = req.sub == 8'h00;
    // group sub-indices 1..4 act; 5 and up never start anything
    wire logic subGroup = !subZero && req.sub <= `CSGO_LAST_GROUP_SUB;
    wire logic subKnown = req.sub <= `CSGO_RESERVED_SUB;
    wire logic isString = isName | isHw | isSw;
    // data arrives already packed little endian, all 32 bits compared
    wire logic saveSigOk = req.data == `CSGO_SIG_SAVE;
    wire logic loadSigOk = req.data == `CSGO_SIG_LOAD;
    wire logic driveBusy = driveOpEnabled | driveQuickStop;
    wire logic take = reqValid && state == CSGO_IDLE;
    wire logic wr = take && req.write;

    // a save is launched only on a correct signature in a group sub
    wire logic saveGo = wr && isSave && subGroup && saveSigOk && !driveBusy;
    wire logic saveRefuse = wr && isSave && subGroup && saveSigOk && driveBusy;
    wire logic loadGo = wr && isRest && subGroup && loadSigOk;

    // ------------------------------------------------------------
    // immediate answer selection
    // ------------------------------------------------------------
    logic [31:0] readData;
    logic [31:0] abortCode;
    logic doAbort;

    always_comb begin
        readData = 32'h0000_0000;
        if (isSync) begin
            readData = syncId;
        end else if (isName) begin
            readData = `CSGO_NAME_STR;
        end else if (isHw) begin
            readData = `CSGO_HWVER_STR;
        end else if (isSw) begin
            readData = `CSGO_SWVER_STR;
        end else if (isGuard) begin
            readData = {16'h0000, guardTime};
        end else if (isLife) begin
            readData = {24'h00_0000, lifeFactor};
        end else if (isArr && subZero) begin
            readData = `CSGO_HIGHEST_SUB;
        end else if (isSave && subGroup) begin
            readData = `CSGO_SAVE_CAP;
        end else if (isRest && subGroup) begin
            readData = `CSGO_RESTORE_CAP;
        end
    end

    always_comb begin
        doAbort = 1'b0;
        abortCode = 32'h0000_0000;
        if (!isVar && !isArr) begin
            doAbort = 1'b1;
            abortCode = `CSGO_AB_NO_OBJ;
        end else if (isVar && !subZero) begin
            doAbort = 1'b1;
            abortCode = `CSGO_AB_NO_SUB;
        end else if (isArr && !subKnown) begin
            doAbort = 1'b1;
            abortCode = `CSGO_AB_NO_SUB;
        end else if (req.write && (isString || (isArr && subZero))) begin
            doAbort = 1'b1;
            abortCode = `CSGO_AB_READ_ONLY;
        end else if (req.write && saveRefuse) begin
            doAbort = 1'b1;
            abortCode = `CSGO_AB_STATE;
        end else if (req.write && isSave && !(subGroup && saveSigOk)) begin
            doAbort = 1'b1;
            abortCode = `CSGO_AB_BAD_SIG;
        end else if (req.write && isRest && !(subGroup && loadSigOk)) begin
            doAbort = 1'b1;
            abortCode = `CSGO_AB_BAD_SIG;
        end
    end

    // ------------------------------------------------------------
    // answer and save sequencer
    // ------------------------------------------------------------
    wire logic saveEnd = state == CSGO_SAVING && (storeDone || storeFail);
    csgo_state_t next_state;

    always_comb begin
        next_state = state;
        case (state)
            CSGO_IDLE: begin
                if (saveGo) begin
                    next_state = CSGO_SAVING;
                end
            end
            CSGO_SAVING: begin
                if (saveEnd) begin
                    next_state = CSGO_IDLE;
                end
            end
            default: begin
                next_state = CSGO_IDLE;
            end
        endcase
    end

    // saves answer only when the store finishes; all else next cycle
    wire logic quickAns = take && !saveGo;
    csgo_rsp_t next_rsp;

    always_comb begin
        next_rsp = '0;
        if (saveEnd) begin
            next_rsp.abort = storeFail;
            next_rsp.data = storeFail ? `CSGO_AB_STORE_FAIL : 32'h0000_0000;
        end else if (quickAns) begin
            next_rsp.abort = doAbort;
            next_rsp.data = doAbort ? abortCode : (req.write ? 32'h0000_0000 : readData);
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state <= CSGO_IDLE;
            rsp <= '0;
            rspValid <= 1'b0;
        end else begin
            state <= next_state;
            rsp <= next_rsp;
            rspValid <= saveEnd | quickAns;
        end
    end

    // held request towards the store until it reports back
    always_ff @(posedge clk) begin
        if (reset) begin
            storeReq <= 1'b0;
            storeGroup <= 8'h00;
        end else if (saveGo) begin
            storeReq <= 1'b1;
            storeGroup <= req.sub;
        end else if (saveEnd) begin
            storeReq <= 1'b0;
        end
    end

    // warning is sticky until reset; the drive clears it by a reset
    always_ff @(posedge clk) begin
        if (reset) begin
            warnPulse <= 1'b0;
            warnSaveRefused <= 1'b0;
        end else begin
            warnPulse <= saveRefuse;
            warnSaveRefused <= warnSaveRefused | saveRefuse;
        end
    end

    // ------------------------------------------------------------
    // writable entries
    // ------------------------------------------------------------
    wire logic wrOk = wr && !doAbort;

    always_ff @(posedge clk) begin
        if (reset) begin
            syncId <= `CSGO_SYNC_RESET;
            guardTime <= `CSGO_GUARD_RESET;
            lifeFactor <= `CSGO_LIFE_RESET;
        end else if (wrOk) begin
            if (isSync) begin
                syncId <= req.data;
            end
            if (isGuard) begin
                guardTime <= req.data[15:0];
            end
            if (isLife) begin
                lifeFactor <= req.data[7:0];
            end
        end
    end

    // ------------------------------------------------------------
    // restore: recorded now, applied at the next matching reset
    // ------------------------------------------------------------
    wire logic applyNode = nmtResetNode && restorePending;
    wire logic applyComm = nmtResetComm && restorePending &&
        pendGroup == `CSGO_COMM_GROUP_SUB;

    always_ff @(posedge clk) begin
        if (reset) begin
            restorePending <= 1'b0;
            pendGroup <= 8'h00;
            restoreApply <= 1'b0;
            restoreGroup <= 8'h00;
        end else begin
            restoreApply <= applyNode | applyComm;
            if (applyNode | applyComm) begin
                restoreGroup <= pendGroup;
            end
            // a new signature in the same cycle keeps the restore pending; the apply still fires for the old group
            if (loadGo) begin
                restorePending <= 1'b1;
                pendGroup <= req.sub;
            end else if (applyNode | applyComm) begin
                restorePending <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // node guarding life timer
    // ------------------------------------------------------------
    logic [31:0] msCnt;
    logic [23:0] lifeMs;
    wire logic [23:0] lifeTime = guardTime * lifeFactor;
    wire logic guardOn = guardTime != 16'h0000 && lifeFactor != 8'h00 &&
        heartbeatTime == 16'h0000;
    wire logic msTick = msCnt == MS_CYCLES - 1;
    wire logic lifeOut = guardOn && msTick && lifeMs == lifeTime - 24'h00_0001;

    // no emergency output exists, so the heartbeat conflict stays silent
    always_ff @(posedge clk) begin
        if (reset || !guardOn || guardRequest || msTick) begin
            msCnt <= 32'h0000_0000;
        end else begin
            msCnt <= msCnt + 32'h0000_0001;
        end
    end

    always_ff @(posedge clk) begin
        if (reset || !guardOn || guardRequest || lifeOut) begin
            lifeMs <= 24'h00_0000;
        end else if (msTick) begin
            lifeMs <= lifeMs + 24'h00_0001;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            guardActive <= 1'b0;
            lifeExpired <= 1'b0;
        end else begin
            guardActive <= guardOn;
            lifeExpired <= lifeOut && !guardRequest;
        end
    end

    // ------------------------------------------------------------
    // sync producer
    // ------------------------------------------------------------
    logic [31:0] syncCnt;
    wire logic syncOn = syncId[`CSGO_SYNC_GEN_BIT];
    wire logic syncDue = syncCnt == SYNC_CYCLES - 1;

    always_ff @(posedge clk) begin
        if (reset || !syncOn || syncDue) begin
            syncCnt <= 32'h0000_0000;
        end else begin
            syncCnt <= syncCnt + 32'h0000_0001;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            syncProducer <= 1'b0;
            syncPulse <= 1'b0;
            syncCobId <= 11'h080;
        end else begin
            syncProducer <= syncOn;
            syncPulse <= syncOn && syncDue;
            syncCobId <= syncId[10:0];
        end
    end

endmodule
`default_nettype wire

// file: tb/csgo_store_guard_chk.sv
// assertion checker for the store, guard and string object block
`timescale 1ns/100ps
`default_nettype none
`include "csgo_params.svh"
module csgo_store_guard_chk
    import csgo_pkg::*;
#(
    parameter int unsigned MS_CYCLES = 10,
    parameter int unsigned SYNC_CYCLES = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // object access
    input wire logic reqValid,
    input wire csgo_req_t req,
    input wire csgo_rsp_t rsp,
    input wire logic rspValid,
    // store, restore and drive state
    input wire logic storeReq,
    input wire logic [7:0] storeGroup,
    input wire logic storeDone,
    input wire logic storeFail,
    input wire logic nmtResetNode,
    input wire logic nmtResetComm,
    input wire logic restorePending,
    input wire logic restoreApply,
    input wire logic [7:0] restoreGroup,
    input wire logic driveOpEnabled,
    input wire logic driveQuickStop,
    input wire logic warnPulse,
    input wire logic warnSaveRefused,
    // guarding and sync
    input wire logic [15:0] heartbeatTime,
    input wire logic guardRequest,
    input wire logic guardActive,
    input wire logic lifeExpired,
    input wire logic syncProducer,
    input wire logic syncPulse,
    input wire logic [10:0] syncCobId
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    // storeReq stands for the saving state, so it gates request taking
    wire taken = reqValid && !storeReq;
    wire saveSig = req.write && req.index == `CSGO_IDX_SAVE && req.sub >= 8'h01
        && req.sub <= 8'h04 && req.data == `CSGO_SIG_SAVE;
    wire stateBad = driveOpEnabled || driveQuickStop;
    sequence s_save_cmd;
        taken && saveSig && !stateBad;
    endsequence
    sequence s_store_end;
        storeReq && storeDone && !storeFail;
    endsequence
    a_sync_gate: assert property (syncPulse |-> syncProducer)
        else $error("sync pulse without producer bit");
    a_save_launch: assert property (s_save_cmd |=>
        storeReq && storeGroup == $past(req.sub))
        else $error("save not launched for its group");
    a_launch_cause: assert property ($rose(storeReq) |->
        $past(taken && saveSig && !stateBad))
        else $error("store started without valid save command");
    a_store_wait: assert property (storeReq && !storeDone && !storeFail |=>
        storeReq && !rspValid)
        else $error("save confirmed before store finished");
    a_store_ok: assert property (s_store_end |=> !storeReq && rspValid && !rsp.abort)
        else $error("finished store not confirmed");
    a_store_fail: assert property (storeReq && storeFail |=>
        rspValid && rsp.abort && rsp.data == `CSGO_AB_STORE_FAIL)
        else $error("failed store without its abort");
    a_refuse_warn: assert property (taken && saveSig && stateBad |=> warnPulse && warnSaveRefused
        && !storeReq && rspValid && rsp.abort && rsp.data == `CSGO_AB_STATE)
        else $error("save in busy drive state not refused");
    a_name_const: assert property (taken && !req.write && req.index == `CSGO_IDX_NAME
        && req.sub == 8'h00 |=> rspValid && rsp.data == `CSGO_NAME_STR)
        else $error("device name read wrong");
    a_hb_wins: assert property (heartbeatTime != 16'h0000 [*2] |-> !guardActive)
        else $error("guarding active beside heartbeat");
    a_apply_cause: assert property (restoreApply |->
        $past(restorePending) && ($past(nmtResetNode) || $past(nmtResetComm)))
        else $error("defaults applied without reset");
    a_comm_group: assert property (restoreApply && !$past(nmtResetNode) |->
        restoreGroup == 8'h02)
        else $error("comm reset applied wrong group");
endmodule
`default_nettype wire

// file: tb/csgo_nv_model.sv
// non-volatile store model answering save requests
`timescale 1ns/100ps
`default_nettype none
module csgo_nv_model (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // store handshake
    input wire logic storeReq,
    output logic storeDone,
    output logic storeFail,
    // bench controls
    input wire logic slowMode,
    input wire logic failMode
);
    int cnt;
    initial begin
        storeDone = 1'b0;
        storeFail = 1'b0;
    end
    // one answer per request, then silent until the request drops
    always @(negedge clk) begin
        storeDone <= 1'b0;
        storeFail <= 1'b0;
        if (reset || !storeReq) begin
            cnt <= 0;
        end else if (cnt == (slowMode ? 12 : 1)) begin
            storeDone <= !failMode;
            storeFail <= failMode;
            cnt <= cnt + 1;
        end else if (cnt < 12) begin
            cnt <= cnt + 1;
        end
    end
endmodule
`default_nettype wire

// file: tb/csgo_store_guard_tb.sv
// self-checking bench for the store, guard and string object block
`timescale 1ns/100ps
`default_nettype none
`include "csgo_params.svh"
module csgo_store_guard_tb
    import csgo_pkg::*;
;
    localparam int unsigned MS = 10;
    localparam int unsigned SYN = 8;
    logic clk = 1'b0, reset = 1'b1, reqValid = 1'b0;
    csgo_req_t req = '0;
    csgo_rsp_t rsp;
    logic rspValid, storeReq, storeDone, storeFail, restorePending, restoreApply;
    logic warnPulse, warnSaveRefused, guardActive, lifeExpired, syncProducer, syncPulse;
    logic [7:0] storeGroup, restoreGroup;
    logic [10:0] syncCobId;
    logic nmtResetNode = 1'b0, nmtResetComm = 1'b0, guardRequest = 1'b0;
    logic driveOpEnabled = 1'b0, driveQuickStop = 1'b0, slowMode = 1'b0, failMode = 1'b0;
    logic [15:0] heartbeatTime = '0;
    int failures = 0, checked = 0, cycles = 0, n;
    always #2.5 clk = ~clk;
    csgo_store_guard #(.MS_CYCLES(MS), .SYNC_CYCLES(SYN)) i_dut (.clk(clk), .reset(reset),
        .reqValid(reqValid), .req(req), .rsp(rsp), .rspValid(rspValid), .storeReq(storeReq),
        .storeGroup(storeGroup), .storeDone(storeDone), .storeFail(storeFail),
        .nmtResetNode(nmtResetNode), .nmtResetComm(nmtResetComm),
        .restorePending(restorePending), .restoreApply(restoreApply),
        .restoreGroup(restoreGroup), .driveOpEnabled(driveOpEnabled),
        .driveQuickStop(driveQuickStop), .warnPulse(warnPulse),
        .warnSaveRefused(warnSaveRefused), .heartbeatTime(heartbeatTime),
        .guardRequest(guardRequest), .guardActive(guardActive), .lifeExpired(lifeExpired),
        .syncProducer(syncProducer), .syncPulse(syncPulse), .syncCobId(syncCobId));
    csgo_nv_model i_nv (.clk(clk), .reset(reset), .storeReq(storeReq), .storeDone(storeDone),
        .storeFail(storeFail), .slowMode(slowMode), .failMode(failMode));
    // ----------------------------------------
    // access and compare tasks
    // ----------------------------------------
    task automatic end_sim;
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input string what, input logic [33:0] exp, input logic [33:0] got);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic acc(input logic w, input logic [15:0] ix, input logic [7:0] sb,
            input logic [31:0] d, input logic ab, input logic [31:0] ed);
        int k;
        @(negedge clk);
        reqValid = 1'b1;
        req = '{w, ix, sb, d};
        @(negedge clk);
        reqValid = 1'b0;
        for (k = 0; k < 40 && rspValid !== 1'b1; k++) @(negedge clk);
        chk("rsp", {1'b1, ab, ed}, {rspValid, rsp});
    endtask
    task automatic nmt(input logic node, input logic [8:0] exp);
        logic [8:0] got;
        got = '0;
        @(negedge clk);
        nmtResetNode = node;
        nmtResetComm = !node;
        @(negedge clk);
        nmtResetNode = 1'b0;
        nmtResetComm = 1'b0;
        repeat (3) begin
            if (restoreApply === 1'b1) got = {1'b1, restoreGroup};
            @(negedge clk);
        end
        chk("restoreApply", exp, got);
    endtask
    task automatic guardIs(input logic exp);
        repeat (3) @(negedge clk);
        chk("guardActive", exp, guardActive);
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            failures++;
            end_sim();
        end
    end
    initial begin
        repeat (8) @(negedge clk);
        reset = 1'b0;
        chk("syncCobId", 34'h080, syncCobId);
        acc(1'b0, `CSGO_IDX_SYNC, 8'h00, '0, 1'b0, `CSGO_SYNC_RESET);
        acc(1'b1, `CSGO_IDX_SYNC, 8'h00, 32'h4000_0080, 1'b0, '0);
        for (n = 0; n < 3 * SYN && syncPulse !== 1'b1; n++) @(negedge clk);
        chk("syncPulse", 34'h1, syncPulse);
        acc(1'b1, `CSGO_IDX_SYNC, 8'h00, `CSGO_SYNC_RESET, 1'b0, '0);
        // producer flag follows the stored id one clock after the write
        @(negedge clk);
        chk("syncProducer", 34'h0, syncProducer);
        acc(1'b0, `CSGO_IDX_NAME, 8'h00, '0, 1'b0, `CSGO_NAME_STR);
        acc(1'b0, `CSGO_IDX_HWVER, 8'h00, '0, 1'b0, `CSGO_HWVER_STR);
        acc(1'b0, `CSGO_IDX_SWVER, 8'h00, '0, 1'b0, `CSGO_SWVER_STR);
        acc(1'b1, `CSGO_IDX_NAME, 8'h00, 32'h1234_5678, 1'b1, `CSGO_AB_READ_ONLY);
        acc(1'b0, `CSGO_IDX_NAME, 8'h00, '0, 1'b0, `CSGO_NAME_STR);
        acc(1'b0, `CSGO_IDX_SAVE, 8'h00, '0, 1'b0, `CSGO_HIGHEST_SUB);
        acc(1'b1, `CSGO_IDX_SAVE, 8'h00, 32'h0000_0007, 1'b1, `CSGO_AB_READ_ONLY);
        for (int s = 1; s <= 4; s++) begin
            acc(1'b0, `CSGO_IDX_SAVE, 8'(s), '0, 1'b0, `CSGO_SAVE_CAP);
            slowMode = (s == 4);
            acc(1'b1, `CSGO_IDX_SAVE, 8'(s), `CSGO_SIG_SAVE, 1'b0, '0);
        end
        slowMode = 1'b0;
        acc(1'b0, `CSGO_IDX_SAVE, 8'h05, '0, 1'b0, '0);
        acc(1'b1, `CSGO_IDX_SAVE, 8'h01, 32'h6576_6174, 1'b1, `CSGO_AB_BAD_SIG);
        acc(1'b1, `CSGO_IDX_SAVE, 8'h01, 32'h7361_7665, 1'b1, `CSGO_AB_BAD_SIG);
        acc(1'b1, `CSGO_IDX_SAVE, 8'h05, `CSGO_SIG_SAVE, 1'b1, `CSGO_AB_BAD_SIG);
        acc(1'b1, `CSGO_IDX_SAVE, 8'h80, `CSGO_SIG_SAVE, 1'b1, `CSGO_AB_NO_SUB);
        failMode = 1'b1;
        acc(1'b1, `CSGO_IDX_SAVE, 8'h02, `CSGO_SIG_SAVE, 1'b1, `CSGO_AB_STORE_FAIL);
        failMode = 1'b0;
        chk("warnSaveRefused", 34'h0, warnSaveRefused);
        driveOpEnabled = 1'b1;
        acc(1'b1, `CSGO_IDX_SAVE, 8'h03, `CSGO_SIG_SAVE, 1'b1, `CSGO_AB_STATE);
        driveOpEnabled = 1'b0;
        driveQuickStop = 1'b1;
        acc(1'b1, `CSGO_IDX_SAVE, 8'h01, `CSGO_SIG_SAVE, 1'b1, `CSGO_AB_STATE);
        driveQuickStop = 1'b0;
        chk("warnSaveRefused", 34'h1, warnSaveRefused);
        acc(1'b0, `CSGO_IDX_RESTORE, 8'h00, '0, 1'b0, `CSGO_HIGHEST_SUB);
        acc(1'b0, `CSGO_IDX_RESTORE, 8'h01, '0, 1'b0, `CSGO_RESTORE_CAP);
        acc(1'b1, `CSGO_IDX_RESTORE, 8'h02, 32'h6c6f_6164, 1'b1, `CSGO_AB_BAD_SIG);
        chk("restorePending", 34'h0, restorePending);
        acc(1'b1, `CSGO_IDX_RESTORE, 8'h05, `CSGO_SIG_LOAD, 1'b1, `CSGO_AB_BAD_SIG);
        acc(1'b1, `CSGO_IDX_RESTORE, 8'h02, `CSGO_SIG_LOAD, 1'b0, '0);
        chk("restorePending", 34'h1, restorePending);
        nmt(1'b0, 9'h102);
        acc(1'b1, `CSGO_IDX_RESTORE, 8'h01, `CSGO_SIG_LOAD, 1'b0, '0);
        nmt(1'b0, 9'h000);
        nmt(1'b1, 9'h101);
        acc(1'b1, `CSGO_IDX_GUARD, 8'h00, 32'h0000_0001, 1'b0, '0);
        guardIs(1'b0);
        acc(1'b1, `CSGO_IDX_LIFE, 8'h00, 32'h0000_0002, 1'b0, '0);
        guardIs(1'b1);
        guardRequest = 1'b1;
        @(negedge clk);
        guardRequest = 1'b0;
        for (n = 0; n < 40 && lifeExpired !== 1'b1; n++) @(negedge clk);
        chk("lifeTime", 34'h1, n >= 2 * MS - 3 && n <= 2 * MS + 1);
        heartbeatTime = 16'h0005;
        guardIs(1'b0);
        heartbeatTime = 16'h0000;
        acc(1'b1, `CSGO_IDX_LIFE, 8'h00, '0, 1'b0, '0);
        guardIs(1'b0);
        acc(1'b1, `CSGO_IDX_LIFE, 8'h00, 32'h0000_0002, 1'b0, '0);
        acc(1'b1, `CSGO_IDX_GUARD, 8'h00, '0, 1'b0, '0);
        guardIs(1'b0);
        end_sim();
    end
endmodule
bind csgo_store_guard csgo_store_guard_chk #(.MS_CYCLES(MS_CYCLES), .SYNC_CYCLES(SYNC_CYCLES))
    i_chk (.clk(clk), .reset(reset), .reqValid(reqValid), .req(req), .rsp(rsp),
    .rspValid(rspValid), .storeReq(storeReq), .storeGroup(storeGroup), .storeDone(storeDone),
    .storeFail(storeFail), .nmtResetNode(nmtResetNode), .nmtResetComm(nmtResetComm),
    .restorePending(restorePending), .restoreApply(restoreApply), .restoreGroup(restoreGroup),
    .driveOpEnabled(driveOpEnabled), .driveQuickStop(driveQuickStop), .warnPulse(warnPulse),
    .warnSaveRefused(warnSaveRefused), .heartbeatTime(heartbeatTime),
    .guardRequest(guardRequest), .guardActive(guardActive), .lifeExpired(lifeExpired),
    .syncProducer(syncProducer), .syncPulse(syncPulse), .syncCobId(syncCobId));
`default_nettype wire
